// [hw/tws_pkg.sv]
/*
  package for the two-wire slave command/status block: register offsets,
  field positions, reset values, state enumeration and carrier structs.
  assumes a byte-wide register port on the system clock.
*/
package tws_pkg;
  localparam logic [7:0] own_address_off = 8'h7c;
  localparam logic [7:0] slave_status_off = 8'h7d;
  localparam logic [7:0] slave_command_off = 8'h7e;
  localparam logic [7:0] slave_data_off = 8'h7a;
  localparam logic [7:0] slave_control_off = 8'h7f;
  localparam logic [7:0] own_address_rst = 8'h00;
  localparam logic [7:0] control_rst = 8'h00;
  // command register fields
  localparam int ack_action_pos = 2;
  // status register fields
  localparam int data_flag_pos = 7;
  localparam int as_flag_pos = 6;
  localparam int hold_pos = 5;
  localparam int rack_pos = 4;
  localparam int coll_pos = 3;
  localparam int berr_pos = 2;
  localparam int dir_pos = 1;
  localparam int cause_pos = 0;
  // control register fields
  localparam int stop_en_pos = 2;
  localparam int accept_all_pos = 1;
  localparam int smart_pos = 0;
  // command codes
  localparam logic [1:0] cmd_nop = 2'h0;
  localparam logic [1:0] cmd_complete = 2'h2;
  localparam logic [1:0] cmd_respond = 2'h3;
  localparam logic [6:0] general_call_addr = 7'h00;
  localparam logic [3:0] bits_per_byte = 4'h9;
  // bus free time and the system clock period, both in ns
  localparam int bus_free_ns = 1300;
  localparam int clk_period_ns = 20;
  localparam bit stop_detect_ok = (clk_period_ns < bus_free_ns);

  typedef enum logic [2:0] {
    st_idle, st_addr, st_ack_wait, st_ack, st_rx, st_tx, st_mack
  } phase_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } pin_drive_s;
endpackage

// [hw/two_wire_slave_command_status.sv]
/*
  two-wire slave core: bit engine, address match, acknowledge actions,
  commands, clock hold and status flags behind a byte register port.
  assumes scl and sda arrive asynchronously and an external master drives scl.
*/
`timescale 1ns/100ps
// Function
// - ack action bit 0 sends ack, 1 sends nack
// - ack action fires on command 1x outside smart mode, or on data read in smart mode
// - ack action also fires on clearing address/stop flag after a match, or tx data flag
// - command 00 does nothing; 01 reserved
// - command 10 acks if receiving, then waits for a start
// - command 11 after address acks, then receives or sets data flag
// - command 11 after data acks on receive, sends the data register on transmit
// - any command write other than 00 releases scl and clears hold and both flags
// - ack bit written with command acts before the command
// - command field reads zero; bits 7..3 read zero
// - data flag set after clean byte, holds scl; cleared by one or command
// - address/stop flag set on match or collision, holds scl
// - stop sets address/stop flag only with stop events enabled
// - clock hold status mirrors held scl with a flag set
// - received ack status keeps last master ack bit
// - collision sets flag, stops sda drive; cleared by one or start
// - bus error when sr or stop comes off a nine-bit boundary
// - direction bit updated from each matched address
// - cause bit 0 for stop, 1 for address
// - match own address bits 7..1; bit 0 enables general call
// - ten-bit first byte matches through the same seven-bit compare
// - accept-all mode answers every address
// - smart mode sends ack action right after data register read
// - any data register access clears both flags and hold
module two_wire_slave_command_status (
  input wire logic clk,
  input wire logic srst,
  input wire tws_pkg::reg_req_s req,
  output logic [7:0] rdata,
  input wire logic scl_i,
  input wire logic sda_i,
  output tws_pkg::pin_drive_s pins
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_q;
    logic sda_q;
    tws_pkg::phase_e ph;
    logic [7:0] shift;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [2:0] bitn;
    logic [3:0] cnt9;
    logic after_start;
    logic is_addr;
    logic ack_val;
    logic hold;
    logic sda_drv;
    logic finish;
    logic [7:0] own;
    logic [7:0] ctrl;
    logic ack_sel;
    logic dflag;
    logic asflag;
    logic rack;
    logic coll;
    logic berr;
    logic dir;
    logic cause;
    logic [7:0] rdata;
  } state_s;

  state_s q;
  state_s n;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic match;
  logic wr_cmd;
  logic [1:0] cmd;
  logic do_ack;
  logic [6:0] rx_addr;

  // edge and condition detection on the second synchroniser stage
  assign scl_rise = q.scl_s[1] && !q.scl_q;
  assign scl_fall = !q.scl_s[1] && q.scl_q;
  assign start_ev = q.scl_s[1] && q.scl_q && q.sda_q && !q.sda_s[1];
  assign stop_ev = q.scl_s[1] && q.scl_q && !q.sda_q && q.sda_s[1];
  // the seven address bits already shifted in when the direction bit arrives
  assign rx_addr = q.shift[6:0];
  // address compare: accept-all, own address (also ten-bit first byte), general call
  assign match = q.ctrl[tws_pkg::accept_all_pos]
    || (rx_addr == q.own[7:1])
    || (q.own[0] && rx_addr == tws_pkg::general_call_addr);
  assign wr_cmd = req.wr && req.addr == tws_pkg::slave_command_off;
  assign cmd = req.wdata[1:0];

  // next state
  always_comb
  begin
    n = q;
    do_ack = 1'b0;
    n.scl_s = {q.scl_s[0], scl_i};
    n.sda_s = {q.sda_s[0], sda_i};
    n.scl_q = q.scl_s[1];
    n.sda_q = q.sda_s[1];
    n.rdata = 8'h00;

    // bit engine
    if (start_ev)
    begin
      // repeated start off a byte boundary
      if (q.ph != tws_pkg::st_idle && q.cnt9 != 4'h0)
        n.berr = 1'b1;
      n.coll = 1'b0;
      n.ph = tws_pkg::st_addr;
      n.bitn = 3'h0;
      n.cnt9 = 4'h0;
      n.after_start = 1'b1;
      n.sda_drv = 1'b0;
      n.hold = 1'b0;
    end
    else if (stop_ev)
    begin
      // stop off a byte boundary or straight after start
      if (q.ph != tws_pkg::st_idle && (q.cnt9 != 4'h0 || q.after_start))
        n.berr = 1'b1;
      // stop event only when enabled and clock fast enough
      if (q.ctrl[tws_pkg::stop_en_pos] && tws_pkg::stop_detect_ok && q.ph != tws_pkg::st_idle)
      begin
        n.asflag = 1'b1;
        n.cause = 1'b0;
      end
      n.ph = tws_pkg::st_idle;
      n.sda_drv = 1'b0;
    end
    else
    begin
      // a bit counts once its clock falls, so the rise before a stop is not a bit
      if (scl_fall && q.ph != tws_pkg::st_idle && !q.after_start)
        n.cnt9 = (q.cnt9 == tws_pkg::bits_per_byte - 4'h1) ? 4'h0 : q.cnt9 + 4'h1;
      case (q.ph)
        tws_pkg::st_addr, tws_pkg::st_rx:
          if (scl_rise)
          begin
            n.shift = {q.shift[6:0], q.sda_s[1]};
            n.bitn = q.bitn + 3'h1;
            n.after_start = 1'b0;
            if (q.bitn == 3'h7)
            begin
              n.is_addr = (q.ph == tws_pkg::st_addr);
              if (q.ph == tws_pkg::st_addr)
              begin
                if (match)
                begin
                  n.asflag = 1'b1;
                  n.cause = 1'b1;
                  n.dir = q.sda_s[1];
                  n.ph = tws_pkg::st_ack_wait;
                end
                else
                  n.ph = tws_pkg::st_idle;
              end
              else
              begin
                n.rxd = {q.shift[6:0], q.sda_s[1]};
                if (!q.coll)
                  n.dflag = 1'b1;
                n.ph = tws_pkg::st_ack_wait;
              end
            end
          end
        tws_pkg::st_ack:
          if (scl_fall)
          begin
            // ack bit is over: let go of sda and move on
            n.sda_drv = 1'b0;
            n.bitn = 3'h0;
            if (q.ack_val || q.finish)
              n.ph = tws_pkg::st_idle;
            else if (q.is_addr && q.dir)
            begin
              n.ph = tws_pkg::st_ack_wait;
              n.is_addr = 1'b0;
              n.dflag = 1'b1;
            end
            else
              n.ph = tws_pkg::st_rx;
          end
          else if (scl_rise && q.ack_val && !q.sda_s[1])
          begin
            n.coll = 1'b1; // nack could not be driven high
            n.asflag = 1'b1;
          end
        tws_pkg::st_tx:
        begin
          if (scl_fall)
          begin
            n.sda_drv = !q.shift[7] && !q.coll;
          end
          if (scl_rise)
          begin
            if (q.shift[7] && !q.sda_s[1] && !q.coll)
            begin
              n.coll = 1'b1;
              n.asflag = 1'b1;
              n.sda_drv = 1'b0;
            end
            n.shift = {q.shift[6:0], 1'b1};
            n.bitn = q.bitn + 3'h1;
            if (q.bitn == 3'h7)
              n.ph = tws_pkg::st_mack;
          end
        end
        tws_pkg::st_mack:
        begin
          if (scl_fall)
            n.sda_drv = 1'b0;
          if (scl_rise)
          begin
            n.rack = q.sda_s[1];
            if (!q.coll)
              n.dflag = 1'b1;
            n.ph = q.sda_s[1] ? tws_pkg::st_idle : tws_pkg::st_ack_wait;
          end
        end
        default:
          ;
      endcase
      // stretch scl on its low phase while a flag is pending
      if ((n.dflag || n.asflag) && !q.scl_s[1])
        n.hold = 1'b1;
    end

    // register writes
    if (req.wr)
    begin
      if (req.addr == tws_pkg::own_address_off)
        n.own = req.wdata;
      else if (req.addr == tws_pkg::slave_control_off)
        n.ctrl = req.wdata;
      else if (req.addr == tws_pkg::slave_data_off)
        n.txd = req.wdata;
      else if (req.addr == tws_pkg::slave_status_off)
      begin
        // the written one clears only a flag already set; one first set in this cycle stays
        if (req.wdata[tws_pkg::coll_pos] && q.coll)
          n.coll = 1'b0;
        if (req.wdata[tws_pkg::berr_pos] && q.berr)
          n.berr = 1'b0;
        // clearing address flag after match or data flag on transmit
        if ((req.wdata[tws_pkg::as_flag_pos] && q.asflag && q.cause)
            || (req.wdata[tws_pkg::data_flag_pos] && q.dflag && q.dir))
          do_ack = 1'b1;
      end
      else if (wr_cmd)
        n.ack_sel = req.wdata[tws_pkg::ack_action_pos];
    end

    // new ack bit taken before the command executes
    if (wr_cmd && cmd[1] && !q.ctrl[tws_pkg::smart_pos])
      do_ack = 1'b1;
    if (req.rd && req.addr == tws_pkg::slave_data_off && q.ctrl[tws_pkg::smart_pos])
      do_ack = 1'b1;

    // acknowledge action and command effects on the engine; only while scl is held,
    // so the first driven level is on sda before the master sees scl rise
    if (do_ack && q.ph == tws_pkg::st_ack_wait && q.hold)
    begin
      n.ack_val = wr_cmd ? req.wdata[tws_pkg::ack_action_pos] : q.ack_sel;
      n.finish = wr_cmd && cmd == tws_pkg::cmd_complete;
      if (q.is_addr || !q.dir)
      begin
        n.ph = tws_pkg::st_ack;
        n.sda_drv = !n.ack_val && !q.coll;
      end
      else
      begin
        n.ph = tws_pkg::st_tx;
        n.shift = q.txd;
        n.bitn = 3'h0;
        n.sda_drv = !q.txd[7] && !q.coll;
      end
    end
    if (wr_cmd && cmd == tws_pkg::cmd_complete && q.dir && q.ph == tws_pkg::st_ack_wait)
    begin
      n.ph = tws_pkg::st_idle;
      n.sda_drv = 1'b0;
    end
    if (wr_cmd && cmd == tws_pkg::cmd_respond && q.is_addr && q.dir && q.ph == tws_pkg::st_ack_wait)
      n.is_addr = 1'b1; // data flag follows on slave transmit

    // flag clears: write-one, command write, data register access
    if (req.wr && req.addr == tws_pkg::slave_status_off)
    begin
      if (req.wdata[tws_pkg::data_flag_pos] && q.dflag)
        n.dflag = 1'b0;
      if (req.wdata[tws_pkg::as_flag_pos] && q.asflag)
        n.asflag = 1'b0;
    end
    if ((wr_cmd && cmd != tws_pkg::cmd_nop)
        || ((req.wr || req.rd) && req.addr == tws_pkg::slave_data_off))
    begin
      n.dflag = 1'b0;
      n.asflag = 1'b0;
    end
    // release scl once no flag is pending
    if (!n.dflag && !n.asflag)
      n.hold = 1'b0;

    // register reads
    if (req.rd)
    begin
      if (req.addr == tws_pkg::own_address_off)
        n.rdata = q.own;
      else if (req.addr == tws_pkg::slave_control_off)
        n.rdata = q.ctrl;
      else if (req.addr == tws_pkg::slave_data_off)
        n.rdata = q.rxd;
      else if (req.addr == tws_pkg::slave_status_off)
        n.rdata = {q.dflag, q.asflag, q.hold, q.rack, q.coll, q.berr, q.dir, q.cause};
      else if (req.addr == tws_pkg::slave_command_off)
        n.rdata = {5'h00, q.ack_sel, 2'h0};
      else
        n.rdata = 8'h00;
    end

    if (srst)
    begin
      n = '0;
      n.ph = tws_pkg::st_idle;
      n.own = tws_pkg::own_address_rst;
      n.ctrl = tws_pkg::control_rst;
      n.scl_s = 2'h3;
      n.sda_s = 2'h3;
      n.scl_q = 1'b1;
      n.sda_q = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk)
    q <= n;

  // pin drive: open drain, enable pulls low
  assign rdata = q.rdata;
  assign pins.scl_o = 1'b0;
  assign pins.scl_oe = q.hold;
  assign pins.sda_o = 1'b0;
  assign pins.sda_oe = q.sda_drv;
endmodule

// [dv/tws_properties.sv]
/*
  concurrent checks on the slave core's register port and pin drives.
  assumes it is bound to the slave core and sees only its ports.
*/
`timescale 1ns/100ps
module tws_properties (
  input wire logic clk,
  input wire logic srst,
  input wire tws_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire tws_pkg::pin_drive_s pins
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // strobe bits and reserved bits of the command register
  a_cmd_reads_zero: assert property (
    req.rd && req.addr == 8'h7e |=> rdata[7:3] == 5'h00 && rdata[1:0] == 2'h0)
    else $error("command register read back nonzero bits");
  // a 1x command write lets go of scl at once
  a_cmd_release: assert property (
    req.wr && req.addr == 8'h7e && req.wdata[1] |=> !pins.scl_oe)
    else $error("scl still held after command write");
  a_cmd_flags_clear: assert property (
    req.wr && req.addr == 8'h7e && req.wdata[1] ##[1:2] req.rd && req.addr == 8'h7d
    |=> rdata[7:5] == 3'h0)
    else $error("flags or hold survived command write");
  // data register access also lets go of scl
  a_data_release: assert property (
    (req.rd || req.wr) && req.addr == 8'h7a |=> !pins.scl_oe)
    else $error("scl still held after data access");
  // hold status follows the pin drive and needs a flag behind it
  a_hold_mirror: assert property (
    req.rd && req.addr == 8'h7d |=> rdata[5] == $past(pins.scl_oe))
    else $error("hold status differs from scl drive");
  a_hold_flagged: assert property (
    req.rd && req.addr == 8'h7d |=> !rdata[5] || rdata[7] || rdata[6])
    else $error("hold status set with no flag");
  a_berr_w1c: assert property (
    req.wr && req.addr == 8'h7d && req.wdata[2] ##[1:2] req.rd && req.addr == 8'h7d
    |=> !rdata[2])
    else $error("bus error not cleared by written one");
  // sda is only pulled low from a cycle in which scl was low or held low
  a_sda_low_start: assert property (
    $rose(pins.sda_oe) |-> $past(pins.scl_oe) || !$past(scl_i))
    else $error("sda pulled low while scl high");
endmodule
bind two_wire_slave_command_status tws_properties i_tws_properties (.clk(clk), .srst(srst),
  .req(req), .rdata(rdata), .scl_i(scl_i), .sda_i(sda_i), .pins(pins));

// [dv/i2c_master_model.sv]
/*
  behavioural two-wire bus master pulling scl and sda low through open drains.
  assumes pull-ups on both wires and a slave that may stretch scl.
*/
`timescale 1ns/100ps
module i2c_master_model (
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_low,
  output logic sda_low
);
  // idle bus: both wires released
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // one bit: data set in the low phase, stretch waited out, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    #40 scl_low = 1'b0;
    wait (scl_w === 1'b1);
    #40 r = sda_w;
    #40 scl_low = 1'b1;
    #40;
  endtask
  task automatic bus_start();
    sda_low = 1'b1;
    #80 scl_low = 1'b1;
    #40;
  endtask
  // stop, then a bus free time above the slave's minimum
  task automatic bus_stop();
    sda_low = 1'b1;
    #40 scl_low = 1'b0;
    wait (scl_w === 1'b1);
    #80 sda_low = 1'b0;
    #1400;
  endtask
  // eight bits msb first, then the slave's acknowledge
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], r);
    bit_io(1'b1, ack);
  endtask
endmodule

// [dv/two_wire_slave_command_status_bench.sv]
/*
  self-checking bench: register port tasks and bus scenarios for the slave core.
  assumes the master model and checker in dv and the core with its package in hw.
*/
`timescale 1ns/100ps
module two_wire_slave_command_status_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  tws_pkg::reg_req_s req = '0;
  logic [7:0] rdata;
  tws_pkg::pin_drive_s pins;
  logic scl_low, sda_low, a, d;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  localparam logic [31:0] tab [6] = '{32'ha000b000, 32'ha1000061, 32'ha0000000,
    32'ha0024461, 32'hf200f261, 32'ha000a163};
  // open-drain wires with pull-ups
  wire scl_w = ~(scl_low | pins.scl_oe);
  wire sda_w = ~(sda_low | pins.sda_oe);
  always #10 clk = ~clk;
  two_wire_slave_command_status i_two_wire_slave_command_status (.clk(clk), .srst(srst),
    .req(req), .rdata(rdata), .scl_i(scl_w), .sda_i(sda_w), .pins(pins));
  i2c_master_model master (.scl_w(scl_w), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low));
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // register port: one-cycle strobes, read data the cycle after
  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    @(posedge clk);
    req.addr <= ad;
    req.wdata <= wd;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    req.addr <= ad;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
  endtask
  task automatic chk(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] e);
    rd(ad);
    cmp(rdata & m, e);
  endtask
  task automatic poll(input logic [7:0] m);
    int n;
    n = 0;
    do
    begin
      rd(8'h7d);
      n++;
    end
    while ((rdata & m) === 8'h00 && n < 500);
  endtask
  task automatic t_reset();
    chk(8'h7c, 8'hff, 8'h00);
    chk(8'h7d, 8'hff, 8'h00);
    chk(8'h7e, 8'hff, 8'h00);
    wr(8'h70, 8'hff);
    chk(8'h70, 8'hff, 8'h00);
    wr(8'h7c, 8'ha5);
    chk(8'h7c, 8'hff, 8'ha5);
    wr(8'h7e, 8'hfc);
    chk(8'h7e, 8'hff, 8'h04);
    wr(8'h7e, 8'h01);
    chk(8'h7e, 8'hff, 8'h00);
  endtask
  task automatic t_write();
    wr(8'h7c, 8'ha0);
    master.bus_start();
    fork
      master.put_byte(8'ha0, a);
      begin
        poll(8'h20);
        chk(8'h7d, 8'hff, 8'h61);
        wr(8'h7e, 8'h03);
        chk(8'h7d, 8'hff, 8'h01);
      end
    join
    cmp({7'h0, a}, 8'h00);
    fork
      master.put_byte(8'h3c, a);
      begin
        poll(8'h20);
        chk(8'h7d, 8'hff, 8'ha1);
        wr(8'h7e, 8'h07);
      end
    join
    cmp({7'h0, a}, 8'h01);
    chk(8'h7a, 8'hff, 8'h3c);
    master.bus_stop();
    chk(8'h7d, 8'h40, 8'h00);
  endtask
  task automatic t_smart();
    wr(8'h7e, 8'h00);
    wr(8'h7f, 8'h05);
    master.bus_start();
    fork
      master.put_byte(8'ha0, a);
      begin
        poll(8'h20);
        wr(8'h7d, 8'h40);
      end
    join
    cmp({7'h0, a}, 8'h00);
    fork
      master.put_byte(8'h5a, a);
      begin
        poll(8'h20);
        chk(8'h7a, 8'hff, 8'h5a);
      end
    join
    cmp({7'h0, a}, 8'h00);
    master.bus_stop();
    poll(8'h40);
    chk(8'h7d, 8'h41, 8'h40);
    wr(8'h7d, 8'h40);
    wr(8'h7f, 8'h00);
  endtask
  // address table: own address, control, byte sent, status on a match
  task automatic t_match();
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h7c, tab[i][31:24]);
      wr(8'h7f, tab[i][23:16]);
      master.bus_start();
      fork
        master.put_byte(tab[i][15:8], a);
        if (tab[i][7:0] != 8'h00)
        begin
          poll(8'h20);
          chk(8'h7d, 8'hff, tab[i][7:0]);
          wr(8'h7e, 8'h06);
        end
      join
      cmp({7'h0, a}, 8'h01);
      chk(8'h7d, 8'hc0, 8'h00);
      master.bus_stop();
    end
  endtask
  // stop after four bits of a byte
  task automatic t_berr();
    master.bus_start();
    repeat (4) master.bit_io(1'b1, d);
    master.bus_stop();
    chk(8'h7d, 8'h04, 8'h04);
    wr(8'h7d, 8'h04);
    chk(8'h7d, 8'h04, 8'h00);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_write();
    t_smart();
    t_match();
    t_berr();
    test_done();
  end
endmodule
